// ### rtl/dat_map.vh
// Register layout, reset values and timing counts for the analog timing and PWM block
`ifndef DAT_MAP_VH
`define DAT_MAP_VH
`define DAT_BIT_DSP_IRQ_ZERO_SEL 15
`define DAT_BIT_RSV9 9
`define DAT_BIT_DAC_RATE 8
`define DAT_BIT_USER_HI 7
`define DAT_BIT_USER_LO 6
`define DAT_BIT_ADC_EN 5
`define DAT_BIT_DONE 4
`define DAT_BIT_TRIG 3
`define DAT_BIT_CLK_SEL 1
`define DAT_BIT_ADC_RATE 0
`define DAT_CTRL_RESET 16'h0208
`define DAT_CTRL_WMASK 16'h81eb
`define DAT_CLK_HZ 125000000
`define DAT_ADC_FAST_HZ 16000
`define DAT_ADC_SLOW20_HZ 8000
`define DAT_ADC_SLOW29_HZ 9600
`define DAT_DAC_A20_HZ 16000
`define DAT_DAC_A29_HZ 8040
`define DAT_DAC_B20_HZ 10000
`define DAT_DAC_B29_HZ 9600
`define DAT_DIV(hz) (`DAT_CLK_HZ / (hz))
`define DAT_ADC_CONV_CYC 8
`define DAT_FIFO_DEPTH 8
`define DAT_FIFO_AW 3
`endif

// ### rtl/dat_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dat_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  reg [AW:0] count;
  reg have_out;
  wire push;
  wire pop_mem;
  wire load_out;
  // Output register counts as one of the words held
  assign in_ready = ((count + {{AW{1'b0}}, have_out}) != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign out_valid = have_out;
  assign load_out = (count != {(AW+1){1'b0}}) && (!have_out || out_ready);
  assign pop_mem = load_out;
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      count <= {(AW+1){1'b0}};
      have_out <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop_mem) begin
        out_data <= mem[rd_ptr[AW-1:0]];
        rd_ptr <= rd_ptr + 1'b1;
        have_out <= 1'b1;
      end else if (out_ready) begin
        have_out <= 1'b0;
      end
      if (push && !pop_mem) begin
        count <= count + 1'b1;
      end else if (!push && pop_mem) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // dat_fifo
`default_nettype wire

// ### rtl/dat_top.v
// Analog control word, sampling timers, A/D handshake and 10-bit PWM generator
`timescale 1ns/1ps
`default_nettype none
`include "dat_map.vh"
module dat_top (
  input wire CLK,
  input wire RST,
  input wire CTRL_WR,
  input wire CTRL_RD,
  input wire DATA_WR,
  input wire DATA_RD,
  input wire [15:0] WDATA,
  output reg [15:0] RDATA,
  output wire DATA_WR_READY,
  input wire DSP_IRQ_ZERO_EXT_SRC,
  output wire USER_OUTPUT_LO,
  output wire USER_OUTPUT_HI,
  output wire ADC_ENABLE,
  output reg ADC_START,
  input wire ADC_DONE,
  input wire [7:0] ADC_RESULT,
  output reg ADC_IRQ,
  output reg DAC_TICK,
  output reg DSP_IRQ_ZERO,
  output reg PWM_OUT
);
  // Divider counts as integers, cut to the counter width below
  localparam integer ADC_FAST_N = `DAT_DIV(`DAT_ADC_FAST_HZ);
  localparam integer ADC_S20_N = `DAT_DIV(`DAT_ADC_SLOW20_HZ);
  localparam integer ADC_S29_N = `DAT_DIV(`DAT_ADC_SLOW29_HZ);
  localparam integer DAC_A20_N = `DAT_DIV(`DAT_DAC_A20_HZ);
  localparam integer DAC_A29_N = `DAT_DIV(`DAT_DAC_A29_HZ);
  localparam integer DAC_B20_N = `DAT_DIV(`DAT_DAC_B20_HZ);
  localparam integer DAC_B29_N = `DAT_DIV(`DAT_DAC_B29_HZ);
  localparam [23:0] ADC_FAST = ADC_FAST_N[23:0];
  localparam [23:0] ADC_S20 = ADC_S20_N[23:0];
  localparam [23:0] ADC_S29 = ADC_S29_N[23:0];
  localparam [23:0] DAC_A20 = DAC_A20_N[23:0];
  localparam [23:0] DAC_A29 = DAC_A29_N[23:0];
  localparam [23:0] DAC_B20 = DAC_B20_N[23:0];
  localparam [23:0] DAC_B29 = DAC_B29_N[23:0];
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_CONV = 2'd1;

  reg [15:0] ctrl;
  reg [7:0] adc_data;
  reg done_flag;
  reg [1:0] adc_state;
  reg [23:0] adc_cnt;
  reg [23:0] dac_cnt;
  wire [23:0] adc_period;
  wire [23:0] dac_period;
  wire adc_tc;
  wire dac_tc;
  wire clk29;
  wire conv_req;

  // Divider terminal count for a given period
  function tc_of;
    input [23:0] cnt;
    input [23:0] period;
    begin
      tc_of = (cnt == period - 24'h000001);
    end
  endfunction

  assign clk29 = ctrl[`DAT_BIT_CLK_SEL];
  assign USER_OUTPUT_LO = ctrl[`DAT_BIT_USER_LO];
  assign USER_OUTPUT_HI = ctrl[`DAT_BIT_USER_HI];
  assign ADC_ENABLE = ctrl[`DAT_BIT_ADC_EN];

  // Control word write
  always @(posedge CLK) begin
    if (RST) begin
      ctrl <= `DAT_CTRL_RESET;
    end else if (CTRL_WR) begin
      ctrl <= (WDATA & `DAT_CTRL_WMASK) | 16'h0200;
    end
  end

  // Timer periods
  assign adc_period = ctrl[`DAT_BIT_ADC_RATE] ? ADC_FAST : (clk29 ? ADC_S29 : ADC_S20);
  assign dac_period = ctrl[`DAT_BIT_DAC_RATE] ? (clk29 ? DAC_B29 : DAC_B20)
                                              : (clk29 ? DAC_A29 : DAC_A20);
  assign adc_tc = tc_of(adc_cnt, adc_period);
  assign dac_tc = tc_of(dac_cnt, dac_period);

  // Free running sampling timers
  always @(posedge CLK) begin
    if (RST) begin
      adc_cnt <= 24'h000000;
      dac_cnt <= 24'h000000;
      DAC_TICK <= 1'b0;
    end else begin
      if (adc_tc || adc_cnt >= adc_period) begin
        adc_cnt <= 24'h000000;
      end else begin
        adc_cnt <= adc_cnt + 24'h000001;
      end
      if (dac_tc || dac_cnt >= dac_period) begin
        dac_cnt <= 24'h000000;
      end else begin
        dac_cnt <= dac_cnt + 24'h000001;
      end
      DAC_TICK <= dac_tc;
    end
  end

  // Conversion request: immediate on trigger write, else on timer
  // Enable written together with the trigger counts at once
  assign conv_req = (CTRL_WR && WDATA[`DAT_BIT_TRIG] && WDATA[`DAT_BIT_ADC_EN]) ||
    (ctrl[`DAT_BIT_ADC_EN] && !ctrl[`DAT_BIT_TRIG] && adc_tc);

  always @(posedge CLK) begin
    if (RST) begin
      adc_state <= ST_IDLE;
      ADC_START <= 1'b0;
      adc_data <= 8'h00;
      done_flag <= 1'b0;
      ADC_IRQ <= 1'b0;
    end else begin
      ADC_START <= 1'b0;
      ADC_IRQ <= 1'b0;
      case (adc_state)
        ST_IDLE: begin
          if (conv_req) begin
            ADC_START <= 1'b1;
            adc_state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (!ctrl[`DAT_BIT_ADC_EN]) begin
            adc_state <= ST_IDLE;
          end else if (ADC_DONE) begin
            adc_data <= ADC_RESULT;
            ADC_IRQ <= 1'b1;
            adc_state <= ST_IDLE;
          end
        end
        default: begin
          adc_state <= ST_IDLE;
        end
      endcase
      if (adc_state == ST_CONV && ctrl[`DAT_BIT_ADC_EN] && ADC_DONE) begin
        done_flag <= 1'b1;
      end else if (DATA_RD) begin
        done_flag <= 1'b0;
      end
    end
  end

  // Read data
  always @(posedge CLK) begin
    if (RST) begin
      RDATA <= 16'h0000;
    end else if (CTRL_RD) begin
      RDATA <= (ctrl & 16'h81eb) | 16'h0200 |
        {11'h000, done_flag, 4'h0};
    end else if (DATA_RD) begin
      RDATA <= {6'h00, adc_data, 2'b00};
    end
  end

  // Interrupt zero source
  always @(posedge CLK) begin
    if (RST) begin
      DSP_IRQ_ZERO <= 1'b0;
    end else begin
      DSP_IRQ_ZERO <= ctrl[`DAT_BIT_DSP_IRQ_ZERO_SEL] ? DSP_IRQ_ZERO_EXT_SRC : dac_tc;
    end
  end

  // D/A sample path through the FIFO
  wire [9:0] fifo_data;
  wire fifo_valid;
  reg [9:0] sample;
  reg [10:0] slot;
  reg [23:0] slot_cnt;
  wire [23:0] slot_len;
  wire period_end;
  wire active;
  wire [4:0] coarse;
  wire [4:0] fine;
  wire [4:0] grp;
  wire [4:0] pos;

  dat_fifo #(.WIDTH(10), .DEPTH(`DAT_FIFO_DEPTH), .AW(`DAT_FIFO_AW)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_data(WDATA[9:0]),
    .in_valid(DATA_WR),
    .in_ready(DATA_WR_READY),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(period_end)
  );

  // Slot length: 1024 slots active; 16 kHz and 8040 Hz rates add 256 forced-low slots
  assign slot_len = ctrl[`DAT_BIT_DAC_RATE] ? (dac_period >> 10) : (dac_period / 24'd1280);
  assign active = ctrl[`DAT_BIT_DAC_RATE] ? 1'b1 : !slot[10];
  assign period_end = (slot_cnt >= slot_len - 24'h000001) &&
    (ctrl[`DAT_BIT_DAC_RATE] ? (slot[9:0] == 10'h3ff) : (slot == 11'h4ff));
  assign coarse = sample[9:5];
  assign fine = sample[4:0];
  assign grp = slot[9:5];
  assign pos = slot[4:0];

  always @(posedge CLK) begin
    if (RST) begin
      slot <= 11'h000;
      slot_cnt <= 24'h000000;
      sample <= 10'h000;
      PWM_OUT <= 1'b0;
    end else begin
      if (slot_cnt >= slot_len - 24'h000001) begin
        slot_cnt <= 24'h000000;
        slot <= period_end ? 11'h000 : slot + 11'h001;
      end else begin
        slot_cnt <= slot_cnt + 24'h000001;
      end
      if (period_end && fifo_valid) begin
        sample <= fifo_data;
      end
      if (!active) begin
        PWM_OUT <= 1'b0;
      end else if (pos == 5'h00) begin
        PWM_OUT <= (grp < fine);
      end else begin
        PWM_OUT <= (pos <= coarse);
      end
    end
  end
endmodule // dat_top
`default_nettype wire

// ### sim/dat_chk.sv
// Port checker for the analog timing and PWM block
`timescale 1ns/1ps
`default_nettype none
module dat_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CTRL_WR,
  input wire logic CTRL_RD,
  input wire logic DATA_RD,
  input wire logic [15:0] WDATA,
  input wire logic [15:0] RDATA,
  input wire logic DSP_IRQ_ZERO_EXT_SRC,
  input wire logic USER_OUTPUT_LO,
  input wire logic USER_OUTPUT_HI,
  input wire logic ADC_ENABLE,
  input wire logic ADC_START,
  input wire logic ADC_DONE,
  input wire logic ADC_IRQ,
  input wire logic DAC_TICK,
  input wire logic DSP_IRQ_ZERO
);
  reg sel;
  always @(posedge CLK) begin
    if (RST) sel <= 1'b0;
    else if (CTRL_WR) sel <= WDATA[15];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence rd_data_s;
    DATA_RD && !ADC_DONE;
  endsequence
  sequence rd_ctrl_s;
    CTRL_RD && !ADC_DONE;
  endsequence
  chk_user_lo_pin: assert property (CTRL_WR |=> USER_OUTPUT_LO == $past(WDATA[6]))
    else $error("lo pin");
  chk_user_hi_pin: assert property (CTRL_WR |=> USER_OUTPUT_HI == $past(WDATA[7]))
    else $error("hi pin");
  chk_adc_enable: assert property (CTRL_WR |=> ADC_ENABLE == $past(WDATA[5]))
    else $error("enable");
  chk_start_now: assert property (CTRL_WR && WDATA[3] && WDATA[5] |=> ADC_START)
    else $error("start");
  chk_done_irq: assert property (ADC_DONE |=> ADC_IRQ)
    else $error("adc irq");
  chk_done_clear: assert property (rd_data_s ##1 !ADC_DONE ##1 rd_ctrl_s |=> !RDATA[4])
    else $error("done clear");
  chk_data_pad: assert property (DATA_RD |=> RDATA[1:0] == 2'b00 && RDATA[15:10] == 6'h00)
    else $error("pad");
  chk_tick_gap: assert property (DAC_TICK |=> !DAC_TICK [*8])
    else $error("tick gap");
  chk_irq_zero_mux: assert property (!$past(RST) |->
    DSP_IRQ_ZERO == ($past(sel) ? $past(DSP_IRQ_ZERO_EXT_SRC) : DAC_TICK))
    else $error("irq zero");
endmodule // dat_chk
bind dat_top dat_chk u_chk (.CLK, .RST, .CTRL_WR, .CTRL_RD, .DATA_RD, .WDATA, .RDATA,
  .DSP_IRQ_ZERO_EXT_SRC, .USER_OUTPUT_LO, .USER_OUTPUT_HI, .ADC_ENABLE, .ADC_START, .ADC_DONE,
  .ADC_IRQ, .DAC_TICK, .DSP_IRQ_ZERO);
`default_nettype wire

// ### sim/dat_adc_model.sv
// Behavioural converter answering start pulses after a set delay
`timescale 1ns/1ps
`default_nettype none
module dat_adc_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [3:0] delay,
  input wire logic [7:0] value,
  output logic done,
  output logic [7:0] result
);
  int cnt = 0;
  initial begin
    done = 1'b0;
    result = 8'h5a;
  end
  always @(posedge clk) begin
    done <= 1'b0;
    result <= ~result;
    if (start) cnt <= delay + 1;
    else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1) begin
      cnt <= 0;
      done <= 1'b1;
      result <= value;
    end
  end
endmodule // dat_adc_model
`default_nettype wire

// ### sim/dat_top_bench.sv
// Self-checking bench for the analog timing and PWM block
`timescale 1ns/1ps
`default_nettype none
`include "dat_map.vh"
module dat_top_bench;
  logic CLK = 0, RST = 1, CTRL_WR = 0, CTRL_RD = 0, DATA_WR = 0, DATA_RD = 0;
  logic DSP_IRQ_ZERO_EXT_SRC = 0;
  logic [15:0] WDATA = 0;
  logic [3:0] dly = 0;
  logic [7:0] val = 0;
  wire [15:0] RDATA;
  wire [7:0] ADC_RESULT;
  wire DATA_WR_READY, USER_OUTPUT_LO, USER_OUTPUT_HI, ADC_ENABLE, ADC_START, ADC_DONE;
  wire ADC_IRQ, DAC_TICK, DSP_IRQ_ZERO, PWM_OUT;
  int fails = 0, samples_checked = 0, n, v, w, c, h, slot;
  dat_top dut (.CLK, .RST, .CTRL_WR, .CTRL_RD, .DATA_WR, .DATA_RD, .WDATA, .RDATA,
    .DATA_WR_READY, .DSP_IRQ_ZERO_EXT_SRC, .USER_OUTPUT_LO, .USER_OUTPUT_HI, .ADC_ENABLE,
    .ADC_START, .ADC_DONE, .ADC_RESULT, .ADC_IRQ, .DAC_TICK, .DSP_IRQ_ZERO, .PWM_OUT);
  dat_adc_model adc (.clk(CLK), .start(ADC_START), .delay(dly), .value(val),
    .done(ADC_DONE), .result(ADC_RESULT));
  always #4 CLK = ~CLK;
  always @(posedge CLK) DSP_IRQ_ZERO_EXT_SRC <= 1'($urandom);
  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(string name, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (exp !== got) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] d);
    CTRL_WR <= 1'b1;
    WDATA <= d;
    @(posedge CLK);
    CTRL_WR <= 1'b0;
  endtask
  task automatic rd(logic dat, logic [15:0] exp, string name);
    if (dat) DATA_RD <= 1'b1;
    else CTRL_RD <= 1'b1;
    @(posedge CLK);
    DATA_RD <= 1'b0;
    CTRL_RD <= 1'b0;
    @(posedge CLK);
    cmp(name, exp, RDATA);
  endtask
  task automatic wait_on(int k);
    h = 0;
    for (c = 1; c < 20000; c++) begin
      @(negedge CLK);
      h += (PWM_OUT === 1'b1);
      if ((k ? DAC_TICK : ADC_IRQ) === 1'b1) begin
        @(posedge CLK);
        return;
      end
    end
    fails++;
    close_out();
  endtask
  initial begin
    v = $urandom(32'h07112591);
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(0, `DAT_CTRL_RESET, "ctrl reset");
    v = $urandom % 1024;
    DATA_WR <= 1'b1;
    WDATA <= 16'(v);
    n = 0;
    repeat (12) begin
      @(negedge CLK);
      n += (DATA_WR_READY === 1'b1);
    end
    @(posedge CLK);
    DATA_WR <= 1'b0;
    cmp("fifo fill", `DAT_FIFO_DEPTH, 16'(n));
    for (int i = 0; i < 3; i++) begin
      dly <= i ? 4'h7 : 4'h0;
      val <= 8'($urandom);
      w = ($urandom & 16'h00c0) | ((i == 2) ? 16'h0021 : 16'h003c);
      wr(16'(w));
      @(negedge CLK);
      cmp("user pins", 16'(w[7:6]), {HI_LO(USER_OUTPUT_HI, USER_OUTPUT_LO)});
      cmp("adc enable", 16'h0001, {15'h0000, ADC_ENABLE});
      wait_on(0);
      rd(0, 16'((w & `DAT_CTRL_WMASK) | 16'h0210), "done set");
      rd(1, {6'h00, val, 2'b00}, "adc data");
      rd(0, 16'((w & `DAT_CTRL_WMASK) | 16'h0200), "done cleared");
    end
    for (int r = 0; r < 2; r++) begin
      wr(r ? 16'h8100 : 16'h0000);
      wait_on(1);
      wait_on(1);
      n = r ? `DAT_DIV(`DAT_DAC_B20_HZ) : `DAT_DIV(`DAT_DAC_A20_HZ);
      slot = r ? n / 1024 : n / 1280;
      cmp("dac period", 16'(n), 16'(c));
      h = 0;
      repeat (slot * (r ? 1024 : 1280)) begin
        @(negedge CLK);
        h += (PWM_OUT === 1'b1);
      end
      cmp("pwm high", 16'(slot * v), 16'(h));
    end
    close_out();
  end
  function automatic logic [15:0] HI_LO(logic hi, logic lo);
    return {14'h0000, hi, lo};
  endfunction
endmodule // dat_top_bench
`default_nettype wire
